// ### hdl/sllp_pkg.sv
// Constants and types shared by the serial latch load port
package sllp_pkg;
   localparam int WORD_W    = 24;
   localparam int SEL_W     = 2;
   localparam int PWRDN_BIT = 20;
   localparam int MON_LSB   = 5;
   localparam int MON_W     = 3;
   localparam int SYNC_W    = 5;

   localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;

   typedef enum logic [SEL_W-1:0] {
      SLLP_SEL_CTRL = 2'b00,
      SLLP_SEL_RDIV = 2'b01,
      SLLP_SEL_FDIV = 2'b10,
      SLLP_SEL_TEST = 2'b11
   } sllp_sel_t;

   typedef enum logic [MON_W-1:0] {
      SLLP_MON_LOW  = 3'b000,
      SLLP_MON_LOCK = 3'b001,
      SLLP_MON_RF   = 3'b010,
      SLLP_MON_REF  = 3'b011
   } sllp_mon_t;

   typedef struct packed {
      logic [WORD_W-1:0] test_w;
      logic [WORD_W-1:0] fdiv_w;
      logic [WORD_W-1:0] rdiv_w;
      logic [WORD_W-1:0] ctrl_w;
   } sllp_latches_t;

   typedef struct packed {
      logic lock_detect;
      logic rf_scaled;
      logic ref_scaled;
   } sllp_mon_src_t;
endpackage

// ### hdl/sllp_sync.sv
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/10ps
module sllp_sync
   import sllp_pkg::*;
#(
   parameter int WIDTH = SYNC_W
)
(
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_nxt;

   always_comb
   begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_r   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r   <= meta_nxt;
         sync_out <= sync_nxt;
      end
   end
endmodule

// ### hdl/sllp_shift.sv
// Serial-clock domain input shift register
`timescale 1ns/10ps
module sllp_shift
   import sllp_pkg::*;
#(
   parameter int WIDTH = WORD_W
)
(
   input  wire logic             serial_clk,
   input  wire logic             resetn,
   input  wire logic             serial_data,
   output logic      [WIDTH-1:0] shift_word
);
   logic [WIDTH-1:0] shift_nxt;

   // MSB first, newest bit enters at bit zero
   always_comb
   begin
      shift_nxt = {shift_word[WIDTH-2:0], serial_data};
   end

   always_ff @(posedge serial_clk or negedge resetn)
   begin
      if (!resetn)
         shift_word <= '0;
      else
         shift_word <= shift_nxt;
   end

   shift_capture_a : assert property (
      @(posedge serial_clk) disable iff (!resetn)
      ##1 shift_word[0] == $past(serial_data) &&
          shift_word[WIDTH-1:1] == $past(shift_word[WIDTH-2:0]))
      else $error("shift register did not take the data bit");
endmodule

// ### hdl/sllp_top.sv
// Serial latch load port: shift register, four latches, power and monitor control
//
// Function
// - Each serial clock rising edge shifts the data bit into the 24-bit register.
// - Load strobe rising copies the shifted word into the selected latch.
// - Chip enable low powers down and floats the charge pump output.
// - Chip enable high powers up only if the software power-down bit allows.
// - Monitor output shows lock detect, scaled RF or scaled reference.
// - Word bits one and zero: 00 control, 01 ref, 10 feedback, 11 test.
`timescale 1ns/10ps
module sllp_top
   import sllp_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   input  wire logic          serial_clk,
   input  wire logic          serial_data,
   input  wire logic          load_strobe,
   input  wire logic          chip_enable,
   input  wire sllp_mon_src_t mon_src,
   input  wire logic          pump_level,
   output sllp_latches_t      latches_r,
   output logic               latch_updated_r,
   output logic               powered_r,
   output logic               monitor_output_r,
   output logic               charge_pump_out_r,
   output logic               charge_pump_oe_n_r
);
   logic [WORD_W-1:0] shift_word;
   logic [SYNC_W-1:0] sync_sys;
   logic              ce_s;
   logic              strobe_s;
   sllp_mon_src_t     mon_s;
   logic              strobe_d_r;
   logic              strobe_rise;

   sllp_latches_t     latches_nxt;
   logic              latch_updated_nxt;
   logic              powered_nxt;
   logic              monitor_nxt;
   logic              cp_out_nxt;
   logic              cp_oe_n_nxt;
   logic              strobe_d_nxt;

   // Latch select from the two trailing word bits
   function automatic sllp_sel_t word_sel(input logic [WORD_W-1:0] w);
      word_sel = sllp_sel_t'(w[SEL_W-1:0]);
   endfunction

   // Monitor source field of the control latch
   function automatic sllp_mon_t mon_field(input logic [WORD_W-1:0] w);
      mon_field = sllp_mon_t'(w[MON_LSB+MON_W-1:MON_LSB]);
   endfunction

   // Word read across domains only while the host holds it still
   sllp_shift #(
      .WIDTH      (WORD_W)
   ) u_shift (
      .serial_clk (serial_clk),
      .resetn     (resetn),
      .serial_data(serial_data),
      .shift_word (shift_word)
   );

   sllp_sync #(
      .WIDTH   (SYNC_W)
   ) u_sync (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .async_in({chip_enable, load_strobe, mon_src}),
      .sync_out(sync_sys)
   );

   always_comb
   begin
      ce_s     = sync_sys[SYNC_W-1];
      strobe_s = sync_sys[SYNC_W-2];
      mon_s    = sllp_mon_src_t'(sync_sys[SYNC_W-3:0]);
   end

   // Edge of the synchronised strobe; the word is quiet while the strobe is high
   assign strobe_rise = strobe_s & ~strobe_d_r;

   always_comb
   begin
      strobe_d_nxt      = strobe_s;
      latches_nxt       = latches_r;
      latch_updated_nxt = 1'b0;
      if (strobe_rise)
      begin
         latch_updated_nxt = 1'b1;
         unique case (word_sel(shift_word))
            SLLP_SEL_CTRL: latches_nxt.ctrl_w = shift_word;
            SLLP_SEL_RDIV: latches_nxt.rdiv_w = shift_word;
            SLLP_SEL_FDIV: latches_nxt.fdiv_w = shift_word;
            SLLP_SEL_TEST: latches_nxt.test_w = shift_word;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         strobe_d_r      <= 1'b0;
         latches_r       <= {LATCH_RST, LATCH_RST, LATCH_RST, LATCH_RST};
         latch_updated_r <= 1'b0;
      end
      else
      begin
         strobe_d_r      <= strobe_d_nxt;
         latches_r       <= latches_nxt;
         latch_updated_r <= latch_updated_nxt;
      end
   end

   // Power, charge pump and monitor
   always_comb
   begin
      powered_nxt = ce_s & ~latches_r.ctrl_w[PWRDN_BIT];
      cp_oe_n_nxt = ~powered_nxt;
      cp_out_nxt  = powered_nxt & pump_level;
      unique case (mon_field(latches_r.ctrl_w))
         SLLP_MON_LOCK: monitor_nxt = mon_s.lock_detect;
         SLLP_MON_RF:   monitor_nxt = mon_s.rf_scaled;
         SLLP_MON_REF:  monitor_nxt = mon_s.ref_scaled;
         default:       monitor_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         powered_r          <= 1'b0;
         charge_pump_oe_n_r <= 1'b1;
         charge_pump_out_r  <= 1'b0;
         monitor_output_r   <= 1'b0;
      end
      else
      begin
         powered_r          <= powered_nxt;
         charge_pump_oe_n_r <= cp_oe_n_nxt;
         charge_pump_out_r  <= cp_out_nxt;
         monitor_output_r   <= monitor_nxt;
      end
   end

   latch_load_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      strobe_rise |=> latch_updated_r ##1 !latch_updated_r)
      else $error("strobe did not give a single update pulse");

   ctrl_decode_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      strobe_rise && shift_word[1:0] == 2'b00 |=>
         latches_r.ctrl_w == $past(shift_word) && $stable(latches_r.fdiv_w))
      else $error("control latch not loaded from word");

   fdiv_decode_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      strobe_rise && shift_word[1:0] == 2'b10 |=>
         latches_r.fdiv_w == $past(shift_word) && $stable(latches_r.rdiv_w))
      else $error("feedback latch not loaded from word");

   latch_hold_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !strobe_rise |=> $stable(latches_r) && !latch_updated_r)
      else $error("latch changed without a strobe edge");

   pump_float_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !ce_s |=> charge_pump_oe_n_r && !powered_r && !charge_pump_out_r)
      else $error("charge pump driven while disabled");

   power_gate_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      ##1 powered_r == ($past(ce_s) && !$past(latches_r.ctrl_w[PWRDN_BIT])))
      else $error("power state does not follow enable and power-down bit");

   monitor_lock_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      mon_field(latches_r.ctrl_w) == SLLP_MON_LOCK |=>
         monitor_output_r == $past(mon_s.lock_detect))
      else $error("monitor does not show lock detect");

   // Monitor selection
   monitor_rf_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      mon_field(latches_r.ctrl_w) == SLLP_MON_RF |=>
         monitor_output_r == $past(mon_s.rf_scaled))
      else $error("monitor does not show scaled feedback");

   monitor_ref_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      mon_field(latches_r.ctrl_w) == SLLP_MON_REF |=>
         monitor_output_r == $past(mon_s.ref_scaled))
      else $error("monitor does not show scaled reference");

   monitor_low_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      mon_field(latches_r.ctrl_w) != SLLP_MON_LOCK &&
      mon_field(latches_r.ctrl_w) != SLLP_MON_RF &&
      mon_field(latches_r.ctrl_w) != SLLP_MON_REF |=>
         !monitor_output_r)
      else $error("monitor not low for an unused selection");

   // Only the selected latch may take the word
   rdiv_decode_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      strobe_rise && word_sel(shift_word) == SLLP_SEL_RDIV |=>
         latches_r.rdiv_w == $past(shift_word) &&
         $stable(latches_r.ctrl_w) &&
         $stable(latches_r.fdiv_w) &&
         $stable(latches_r.test_w))
      else $error("reference latch not loaded from word");

   ctrl_only_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !(strobe_rise && word_sel(shift_word) == SLLP_SEL_CTRL) |=>
         $stable(latches_r.ctrl_w))
      else $error("control latch changed without its select");

   rdiv_only_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !(strobe_rise && word_sel(shift_word) == SLLP_SEL_RDIV) |=>
         $stable(latches_r.rdiv_w))
      else $error("reference latch changed without its select");

   fdiv_only_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !(strobe_rise && word_sel(shift_word) == SLLP_SEL_FDIV) |=>
         $stable(latches_r.fdiv_w))
      else $error("feedback latch changed without its select");

   test_only_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !(strobe_rise && word_sel(shift_word) == SLLP_SEL_TEST) |=>
         $stable(latches_r.test_w))
      else $error("test latch changed without its select");

   update_cause_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      latch_updated_r |->
         $past(strobe_s) && !$past(strobe_d_r))
      else $error("latch update without a strobe edge");

   strobe_held_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      strobe_s && strobe_d_r |=>
         !latch_updated_r &&
         $stable(latches_r))
      else $error("latch reloaded while strobe stays high");

   pulse_single_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      latch_updated_r |=>
         !latch_updated_r)
      else $error("update pulse longer than one cycle");

   // Power gating of the charge pump
   pump_drive_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      ce_s && !latches_r.ctrl_w[PWRDN_BIT] |=>
         powered_r &&
         !charge_pump_oe_n_r &&
         charge_pump_out_r == $past(pump_level))
      else $error("charge pump not driven while powered");

   soft_down_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      latches_r.ctrl_w[PWRDN_BIT] |=>
         !powered_r &&
         charge_pump_oe_n_r &&
         !charge_pump_out_r)
      else $error("device powered despite power-down bit");

   soft_cmd_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      strobe_rise && word_sel(shift_word) == SLLP_SEL_CTRL &&
      shift_word[PWRDN_BIT] |=>
         ##1 !powered_r && charge_pump_oe_n_r)
      else $error("power-down word did not power down");

   enable_up_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      $rose(ce_s) && !latches_r.ctrl_w[PWRDN_BIT] |=>
         powered_r && !charge_pump_oe_n_r)
      else $error("enable did not power up the device");

   pump_oe_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      charge_pump_oe_n_r |->
         !charge_pump_out_r && !powered_r)
      else $error("pump output active while floating");

   powered_oe_a : assert property (
      @(posedge sys_clk) disable iff (!resetn)
      powered_r |->
         !charge_pump_oe_n_r)
      else $error("pump floating while powered");
endmodule

// ### test/sllp_host.sv
// Host model driving the three-wire serial port
`timescale 1ns/10ps
module sllp_host;
   logic serial_clk  = 1'b0;
   logic serial_data = 1'b0;
   logic load_strobe = 1'b0;

   // Whole word MSB first; clock stands still between words
   task automatic send_word(input logic [23:0] w, input logic ld);
      for (int i = 23; i >= 0; i--)
      begin
         serial_data = w[i];
         #16 serial_clk = 1'b1;
         #16 serial_clk = 1'b0;
      end
      serial_data = ~w[0];
      #100 load_strobe = ld;
      #400 load_strobe = 1'b0;
      #400;
   endtask
endmodule

// ### test/sllp_top_tb.sv
// Self-checking bench for the serial latch load port
`timescale 1ns/10ps
module sllp_top_tb;
   import sllp_pkg::*;
   logic          sys_clk     = 1'b0;
   logic          resetn      = 1'b0;
   logic          chip_enable = 1'b0;
   logic          pump_level  = 1'b0;
   sllp_mon_src_t mon_src     = '0;
   sllp_latches_t latches_r;
   sllp_latches_t exp_l       = '0;
   logic          upd_r;
   logic          pwr_r;
   logic          mon_r;
   logic          cp_r;
   logic          oen_r;
   int            error_cnt    = 0;
   int            total_checks = 0;
   int            upd_cnt      = 0;
   int            cyc          = 0;

   sllp_host u_host();
   sllp_top u_dut(.sys_clk(sys_clk), .resetn(resetn), .serial_clk(u_host.serial_clk),
      .serial_data(u_host.serial_data), .load_strobe(u_host.load_strobe),
      .chip_enable(chip_enable), .mon_src(mon_src), .pump_level(pump_level),
      .latches_r(latches_r), .latch_updated_r(upd_r), .powered_r(pwr_r),
      .monitor_output_r(mon_r), .charge_pump_out_r(cp_r), .charge_pump_oe_n_r(oen_r));

   always #50 sys_clk = ~sys_clk;

   task automatic summarize();
      $display("Checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cyc++;
      if (upd_r === 1'b1)
         upd_cnt++;
      if (cyc == 20000)
      begin
         error_cnt++;
         summarize();
      end
   end

   task automatic check(input string name, input logic [95:0] e, input logic [95:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // One word through the host, then pulse count and latch image
   task automatic wr(input logic [23:0] w, input logic ld);
      int n;
      n = upd_cnt;
      u_host.send_word(w, ld);
      if (ld)
         case (w[1:0])
            2'b00: exp_l.ctrl_w = w;
            2'b01: exp_l.rdiv_w = w;
            2'b10: exp_l.fdiv_w = w;
            default: exp_l.test_w = w;
         endcase
      check("pulses", 96'(ld), 96'(upd_cnt - n));
      check("latches", exp_l, latches_r);
   endtask

   task automatic t_load();
      // No word addresses the test latch
      wr(24'h123455, 1'b1);
      wr(24'h000020, 1'b1);
      wr(24'hABCDE6, 1'b1);
      wr(24'hFFFFFC, 1'b0);
      $display("Test load done");
   endtask

   task automatic t_power();
      wt(1);
      chip_enable = 1'b1;
      pump_level = 1'b1;
      wt(4);
      check("powered", 96'(1), 96'(pwr_r));
      check("oe_n", 96'(0), 96'(oen_r));
      check("cp_out", 96'(1), 96'(cp_r));
      pump_level = 1'b0;
      wt(2);
      check("cp_out", 96'(0), 96'(cp_r));
      pump_level = 1'b1;
      chip_enable = 1'b0;
      wt(4);
      check("powered", 96'(0), 96'(pwr_r));
      check("oe_n", 96'(1), 96'(oen_r));
      check("cp_out", 96'(0), 96'(cp_r));
      chip_enable = 1'b1;
      wr(24'h100020, 1'b1);
      wt(4);
      check("powered", 96'(0), 96'(pwr_r));
      check("oe_n", 96'(1), 96'(oen_r));
      $display("Test power done");
   endtask

   task automatic t_mon();
      for (int s = 0; s < 4; s++)
      begin
         wr(24'(s) << 5, 1'b1);
         check("powered", 96'(1), 96'(pwr_r));
         for (int p = 0; p < 2; p++)
         begin
            wt(1);
            mon_src = (p == 0) ? 3'h5 : 3'h2;
            wt(4);
            check("monitor", 96'((s == 0) ? 1'b0 : mon_src[3-s]), 96'(mon_r));
         end
      end
      $display("Test monitor done");
   endtask

   task automatic t_reset();
      check("reset latches", 96'(0), latches_r);
      check("reset oe_n", 96'(1), 96'(oen_r));
      check("reset powered", 96'(0), 96'(pwr_r));
      check("reset monitor", 96'(0), 96'(mon_r));
      $display("Test reset done");
   endtask

   initial
   begin
      wt(5);
      resetn = 1'b1;
      t_reset();
      t_load();
      t_power();
      t_mon();
      summarize();
   end
endmodule
